// ==== hw/pbdw_top.sv ====
// What this block does
// R1 - system control region takes four core cycles
// R2 - core-side control region takes three core cycles
// R3 - io region: three, else two-three, unit B
// R4 - data-op and converter region, same counts
// R5 - flash control region always seven cycles
// R6 - masters avoid reserved addresses, result undefined; holes here get ack with err next cycle
// R7 - equal clocks give constant synchronisation cycles
// R8 - faster core adds one unit-B cycle minimum
// R9 - counts hold only without contention; contention stretches
// R10 - six pwm timers, bases 0x100 apart
// R11 - port blocks spaced 0x20 from port base
// R12 - two low-power timers, 0x100 apart
// R13 - unit base is its lowest decoded address
// R14 - pwm all-equal clocks: read six, write four
// R15 - fractional counts: floor minimum, ceiling maximum
// R16 - stall master until count elapses, then answer
`default_nettype none
module pbdw_top (
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  req_in,
	input  wire logic [31:0]           addr_in,
	input  wire logic                  write_in,
	input  wire logic [31:0]           wdata_in,
	input  wire logic                  clocks_equal_in,
	input  wire pbdw_pkg::pbdw_ratio_t pwm_ratio_in,
	input  wire logic                  peripheral_clock_b_tick_in,
	input  wire logic                  contention_in,
	input  wire logic [31:0]           periph_rdata_in,
	output logic                       wait_out,
	output logic                       ack_out,
	output logic                       err_out,
	output logic [31:0]                rdata_out,
	output logic                       psel_out,
	output pbdw_pkg::pbdw_region_t     region_out,
	output logic [3:0]                 unit_out,
	output logic [31:0]                paddr_out,
	output logic                       pwrite_out,
	output logic [31:0]                pwdata_out
);
	import pbdw_pkg::*;

	typedef enum logic {ST_IDLE, ST_BUSY} pbdw_state_t;

	typedef struct packed {
		pbdw_state_t          st;
		pbdw_cnt_t            cnt;
		logic                 pclk_unit;
		pbdw_region_t         region;
		logic [UNIT_W-1:0]    unit;
		logic [ADDR_W-1:0]    addr;
		logic                 write;
		logic [DATA_W-1:0]    wdata;
		logic [DATA_W-1:0]    rdata;
		logic                 busy;
		logic                 ack;
		logic                 err;
	} pbdw_core_t;

	localparam pbdw_core_t CORE_RST = '0;

	////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta;
	logic rst_sync;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// decode of the incoming request
	pbdw_region_t dec_region;
	logic [3:0]   dec_unit;
	pbdw_cnt_t    dec_count;
	logic         dec_pclk;

	pbdw_region_decode u_decode (
		.addr_in         (addr_in),
		.write_in        (write_in),
		.clocks_equal_in (clocks_equal_in),
		.ratio_in        (pwm_ratio_in),
		.region_out      (dec_region),
		.unit_out        (dec_unit),
		.count_out       (dec_count),
		.pclk_unit_out   (dec_pclk)
	);

	////////////////////////////////////////////////////////////////////
	// access sequencer
	pbdw_core_t r;
	pbdw_core_t nx;
	logic       acc;
	logic       step;

	assign acc = (r.st == ST_IDLE) && req_in;

	always_comb begin
		nx = r;
		nx.ack = 1'b0;
		nx.err = 1'b0;
		// unit-B regions advance only on a unit-B edge unless the
		// clocks match; waiting for the first edge is the sync cost
		step = !contention_in && // see R9
			(!r.pclk_unit || clocks_equal_in || peripheral_clock_b_tick_in); // see R7, R8, R15
		case (r.st)
		ST_IDLE: begin
			if (req_in) begin
				nx.region = dec_region;
				nx.unit = dec_unit;
				nx.addr = addr_in;
				nx.write = write_in;
				nx.wdata = wdata_in;
				nx.pclk_unit = dec_pclk;
				if (dec_region == RG_NONE) begin
					// holes answer at once so a stray access cannot hang the bus
					nx.ack = 1'b1; // see R6
					nx.err = 1'b1;
					nx.rdata = '0;
				end else begin
					nx.st = ST_BUSY; // see R16
					nx.cnt = dec_count;
					nx.busy = 1'b1;
				end
			end
		end
		ST_BUSY: begin
			if (step) begin
				if (r.cnt == CNT_ERR) begin
					nx.st = ST_IDLE; // see R16
					nx.busy = 1'b0;
					nx.ack = 1'b1;
					if (!r.write)
						nx.rdata = periph_rdata_in;
				end else begin
					nx.cnt = r.cnt - CNT_ERR;
				end
			end
		end
		default: begin
			nx = CORE_RST;
		end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_sync) begin
		if (!rst_sync)
			r <= CORE_RST;
		else
			r <= nx;
	end

	assign wait_out = r.busy;
	assign psel_out = r.busy;
	assign ack_out = r.ack;
	assign err_out = r.err;
	assign rdata_out = r.rdata;
	assign region_out = r.region;
	assign unit_out = r.unit;
	assign paddr_out = r.addr;
	assign pwrite_out = r.write;
	assign pwdata_out = r.wdata;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_sync);

	a_sysctl_four: assert property ( // see R1
		acc && dec_region == RG_SYSCTL ##1 !contention_in [*4]
		|=> ack_out && !err_out)
		else $error("system control access not four cycles");

	a_core_three: assert property ( // see R2
		acc && dec_region == RG_CORE ##1 !contention_in [*3]
		|-> !ack_out ##1 ack_out)
		else $error("core region access not three cycles");

	a_pb_equal: assert property ( // see R3
		acc && clocks_equal_in && (dec_region == RG_IO ||
		dec_region == RG_DATAOP || dec_region == RG_LPT)
		##1 (clocks_equal_in && !contention_in) [*3]
		|=> ack_out)
		else $error("unit-B access with equal clocks not three");

	a_flash_seven: assert property ( // see R5
		acc && dec_region == RG_FLASH ##1 !contention_in [*7]
		|=> ack_out)
		else $error("flash access not seven cycles");

	a_sync_added: assert property ( // see R8
		acc && dec_pclk && !clocks_equal_in
		|=> !ack_out ##1 !ack_out)
		else $error("unequal-clock access finished too early");

	a_contention_hold: assert property ( // see R9
		wait_out && contention_in |=> !ack_out && $stable(r.cnt))
		else $error("access advanced under contention");

	a_pwm_unit: assert property ( // see R10
		acc && addr_in >= PWM_BASE && addr_in <= PWM_TOP
		|=> region_out == RG_PWM && unit_out ==
		UNIT_W'(($past(addr_in) - PWM_BASE) >> PWM_SH))
		else $error("pwm channel index wrong");

	a_port_unit: assert property ( // see R11
		acc && addr_in >= PORT_BASE && addr_in <= PORT_TOP
		|=> unit_out == UNIT_W'(($past(addr_in) - PORT_BASE) >> PORT_SH))
		else $error("port block index wrong");

	a_lpt_unit: assert property ( // see R12
		acc && addr_in >= LPT_BASE && addr_in <= LPT_TOP
		|=> region_out == RG_LPT && unit_out ==
		UNIT_W'(($past(addr_in) - LPT_BASE) >> LPT_SH))
		else $error("low-power timer index wrong");

	a_pwm_equal: assert property ( // see R14
		acc && dec_region == RG_PWM && pwm_ratio_in == PR_ALL_EQ &&
		!write_in ##1 (!contention_in && clocks_equal_in) [*6]
		|=> ack_out)
		else $error("pwm read with equal clocks not six");

	// a hole taken in the ack cycle answers again at once
	a_ack_pulse: assert property ( // see R16
		ack_out |-> !wait_out ##1
		(!ack_out || $past(acc && dec_region == RG_NONE)))
		else $error("ack not a single pulse after wait");

	a_hole_err: assert property ( // see R6
		acc && dec_region == RG_NONE |=> ack_out && err_out && !wait_out)
		else $error("unmapped access not answered with error");

	c_flash: cover property (acc && dec_region == RG_FLASH);
	c_pwm_wr: cover property (acc && dec_region == RG_PWM && write_in);
	c_stall: cover property (wait_out && contention_in);
	c_hole: cover property (ack_out && err_out);
endmodule
`default_nettype wire

// ==== pkg/pbdw_pkg.sv ====
`default_nettype none
package pbdw_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 4;
	localparam int UNIT_W = 4;

	typedef logic [ADDR_W-1:0] pbdw_addr_t;
	typedef logic [CNT_W-1:0]  pbdw_cnt_t;

	typedef enum logic [3:0] {
		RG_NONE, RG_CORE, RG_SYSCTL, RG_IO, RG_DATAOP,
		RG_SERIAL, RG_MISC, RG_PWM, RG_LPT, RG_FLASH
	} pbdw_region_t;

	// clock ratio rows for pwm timer accesses
	typedef enum logic [2:0] {
		PR_CORE_GT_D_EQ_B, PR_CORE_GT_D_GT_B, PR_ALL_EQ,
		PR_D_EQ_CORE_GT_B, PR_D_GT_CORE_EQ_B, PR_D_GT_CORE_GT_B
	} pbdw_ratio_t;

	////////////////////////////////////////////////////////////////////
	// region bounds, inclusive
	localparam pbdw_addr_t CORE_LO  = 32'h4000_2000;
	localparam pbdw_addr_t CORE_HI  = 32'h4001_BFFF;
	localparam pbdw_addr_t SYS_LO   = 32'h4001_E000;
	localparam pbdw_addr_t SYS_HI   = 32'h4001_E6FF;
	localparam pbdw_addr_t IO_LO    = 32'h4004_0000;
	localparam pbdw_addr_t IO_HI    = 32'h4004_7FFF;
	localparam pbdw_addr_t DOP_LO   = 32'h4005_4100;
	localparam pbdw_addr_t DOP_HI   = 32'h4005_EFFF;
	localparam pbdw_addr_t SCI_LO   = 32'h4007_0000;
	localparam pbdw_addr_t SCI_HI   = 32'h4007_0EFF;
	localparam pbdw_addr_t SPI_LO   = 32'h4007_2000;
	localparam pbdw_addr_t SPI_HI   = 32'h4007_20FF;
	localparam pbdw_addr_t CRC_LO   = 32'h4007_4000;
	localparam pbdw_addr_t CRC_HI   = 32'h4007_4FFF;
	localparam pbdw_addr_t PWM_LO   = 32'h4007_8000;
	localparam pbdw_addr_t PWM_HI   = 32'h4007_BFFF;
	localparam pbdw_addr_t KINT_LO  = 32'h4008_0000;
	localparam pbdw_addr_t KINT_HI  = 32'h4008_2FFF;
	localparam pbdw_addr_t I3C_LO   = 32'h4008_3000;
	localparam pbdw_addr_t I3C_HI   = 32'h4008_33D0;
	localparam pbdw_addr_t LPT_LO   = 32'h4008_4000;
	localparam pbdw_addr_t LPT_HI   = 32'h4008_4FFF;
	localparam pbdw_addr_t FLASH_LO = 32'h407E_C000;
	localparam pbdw_addr_t FLASH_HI = 32'h407E_FFFF;

	////////////////////////////////////////////////////////////////////
	// unit bases and strides inside regions
	localparam pbdw_addr_t PORT_BASE = 32'h4004_0000;
	localparam pbdw_addr_t PORT_TOP  = 32'h4004_013F;
	localparam int         PORT_SH   = 5;
	localparam pbdw_addr_t PWM_BASE  = 32'h4007_8400;
	localparam pbdw_addr_t PWM_TOP   = 32'h4007_89FF;
	localparam int         PWM_SH    = 8;
	localparam pbdw_addr_t LPT_BASE  = 32'h4008_4000;
	localparam pbdw_addr_t LPT_TOP   = 32'h4008_41FF;
	localparam int         LPT_SH    = 8;

	////////////////////////////////////////////////////////////////////
	// access cycle counts
	localparam pbdw_cnt_t CNT_SYSCTL = 4'h4;
	localparam pbdw_cnt_t CNT_CORE   = 4'h3;
	localparam pbdw_cnt_t CNT_PB_EQ  = 4'h3;
	localparam pbdw_cnt_t CNT_SER_EQ = 4'h5;
	localparam pbdw_cnt_t CNT_PB_MIN = 4'h2;
	localparam pbdw_cnt_t CNT_FLASH  = 4'h7;
	localparam pbdw_cnt_t CNT_ERR    = 4'h1;
	localparam int        PWM_ROWS   = 6;
	// lower bound of each range; the tick wait supplies the rest
	localparam pbdw_cnt_t PWM_RD [PWM_ROWS] =
		'{4'h5, 4'h3, 4'h6, 4'h2, 4'h4, 4'h2};
	localparam pbdw_cnt_t PWM_WR [PWM_ROWS] =
		'{4'h3, 4'h2, 4'h4, 4'h1, 4'h3, 4'h1};
endpackage
`default_nettype wire

// ==== hw/pbdw_region_decode.sv ====
`default_nettype none
module pbdw_region_decode (
	input  wire logic [31:0]          addr_in,
	input  wire logic                 write_in,
	input  wire logic                 clocks_equal_in,
	input  wire pbdw_pkg::pbdw_ratio_t ratio_in,
	output pbdw_pkg::pbdw_region_t    region_out,
	output logic [3:0]                unit_out,
	output pbdw_pkg::pbdw_cnt_t       count_out,
	output logic                      pclk_unit_out
);
	import pbdw_pkg::*;

	function automatic logic in_rng(input pbdw_addr_t a,
		input pbdw_addr_t lo, input pbdw_addr_t hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// unit index counted up from the lowest address of a unit
	function automatic logic [UNIT_W-1:0] unit_of(input pbdw_addr_t a,
		input pbdw_addr_t base, input int sh);
		pbdw_addr_t off;
		off = a - base;
		return UNIT_W'(off >> sh);
	endfunction

	pbdw_ratio_t row;

	always_comb begin
		region_out = RG_NONE;
		if (in_rng(addr_in, CORE_LO, CORE_HI)) // see R2
			region_out = RG_CORE;
		else if (in_rng(addr_in, SYS_LO, SYS_HI)) // see R1
			region_out = RG_SYSCTL;
		else if (in_rng(addr_in, IO_LO, IO_HI)) // see R3
			region_out = RG_IO;
		else if (in_rng(addr_in, DOP_LO, DOP_HI)) // see R4
			region_out = RG_DATAOP;
		else if (in_rng(addr_in, SCI_LO, SCI_HI) ||
			in_rng(addr_in, SPI_LO, SPI_HI))
			region_out = RG_SERIAL;
		else if (in_rng(addr_in, CRC_LO, CRC_HI) ||
			in_rng(addr_in, KINT_LO, KINT_HI) ||
			in_rng(addr_in, I3C_LO, I3C_HI))
			region_out = RG_MISC;
		else if (in_rng(addr_in, PWM_LO, PWM_HI))
			region_out = RG_PWM;
		else if (in_rng(addr_in, LPT_LO, LPT_HI)) // see R12
			region_out = RG_LPT;
		else if (in_rng(addr_in, FLASH_LO, FLASH_HI)) // see R5
			region_out = RG_FLASH;
	end

	always_comb begin
		unit_out = '0;
		if (in_rng(addr_in, PORT_BASE, PORT_TOP)) // see R11, R13
			unit_out = unit_of(addr_in, PORT_BASE, PORT_SH);
		else if (in_rng(addr_in, PWM_BASE, PWM_TOP)) // see R10, R13
			unit_out = unit_of(addr_in, PWM_BASE, PWM_SH);
		else if (in_rng(addr_in, LPT_BASE, LPT_TOP)) // see R12, R13
			unit_out = unit_of(addr_in, LPT_BASE, LPT_SH);
	end

	always_comb begin
		// undefined ratio codes fall back to the all-equal row
		row = (int'(ratio_in) < PWM_ROWS) ? ratio_in : PR_ALL_EQ;
		pclk_unit_out = 1'b1;
		case (region_out)
		RG_CORE: begin
			count_out = CNT_CORE; // see R2
			pclk_unit_out = 1'b0;
		end
		RG_SYSCTL: begin
			count_out = CNT_SYSCTL; // see R1
			pclk_unit_out = 1'b0;
		end
		RG_FLASH: begin
			count_out = CNT_FLASH; // see R5
			pclk_unit_out = 1'b0;
		end
		RG_SERIAL:
			count_out = clocks_equal_in ? CNT_SER_EQ : CNT_PB_MIN;
		RG_IO, RG_DATAOP, RG_MISC, RG_LPT: // see R3, R4, R12
			count_out = clocks_equal_in ? CNT_PB_EQ : CNT_PB_MIN;
		RG_PWM: // see R14
			count_out = write_in ? PWM_WR[row] : PWM_RD[row];
		default: begin
			count_out = CNT_ERR;
			pclk_unit_out = 1'b0;
		end
		endcase
	end
endmodule
`default_nettype wire

// ==== testbench/pbdw_periph_model.sv ====
`default_nettype none
module pbdw_periph_model (
	input  wire logic        clk_in,
	input  wire logic        psel_in,
	input  wire logic [31:0] paddr_in,
	output logic      [31:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] spin = 32'h1;
	// unselected bus moves every cycle so stale data never matches
	always_ff @(posedge clk_in) begin
		spin <= spin + 32'h3B9A_CA07;
	end
	assign rdata_out = psel_in ? (paddr_in ^ 32'h5A5A_0000) : spin;
endmodule
`default_nettype wire

// ==== testbench/test_peripheral_bus_decode_wait.sv ====
`default_nettype none
module test_peripheral_bus_decode_wait;
	timeunit 1ns;
	timeprecision 1ns;
	import pbdw_pkg::*;
	localparam int NR = 12;
	logic core_clk_in, rst_n_in, req_in, write_in, clocks_equal_in;
	logic peripheral_clock_b_tick_in, contention_in;
	logic [31:0] addr_in, wdata_in, periph_rdata_in;
	pbdw_ratio_t pwm_ratio_in;
	logic wait_out, ack_out, err_out, psel_out, pwrite_out;
	logic [31:0] rdata_out, paddr_out, pwdata_out;
	pbdw_region_t region_out;
	logic [3:0] unit_out;
	int err_count = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h5DCB;
	pbdw_addr_t lo_t [NR] = '{CORE_LO, SYS_LO, IO_LO, DOP_LO, SCI_LO,
		SPI_LO, CRC_LO, PWM_LO, KINT_LO, I3C_LO, LPT_LO, FLASH_LO};
	pbdw_addr_t hi_t [NR] = '{CORE_HI, SYS_HI, IO_HI, DOP_HI, SCI_HI,
		SPI_HI, CRC_HI, PWM_HI, KINT_HI, I3C_HI, LPT_HI, FLASH_HI};
	int neq_t [NR] = '{3, 4, 3, 3, 5, 5, 3, 0, 3, 3, 3, 7};
	// core, sysctl and flash count core cycles
	logic [NR-1:0] pbm = 12'h7FC;
	pbdw_region_t rg_t [NR] = '{RG_CORE, RG_SYSCTL, RG_IO, RG_DATAOP,
		RG_SERIAL, RG_SERIAL, RG_MISC, RG_PWM, RG_MISC, RG_MISC, RG_LPT,
		RG_FLASH};

	pbdw_top u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.req_in(req_in), .addr_in(addr_in), .write_in(write_in),
		.wdata_in(wdata_in), .clocks_equal_in(clocks_equal_in),
		.pwm_ratio_in(pwm_ratio_in), .peripheral_clock_b_tick_in(peripheral_clock_b_tick_in),
		.contention_in(contention_in), .periph_rdata_in(periph_rdata_in),
		.wait_out(wait_out), .ack_out(ack_out), .err_out(err_out),
		.rdata_out(rdata_out), .psel_out(psel_out),
		.region_out(region_out), .unit_out(unit_out),
		.paddr_out(paddr_out), .pwrite_out(pwrite_out),
		.pwdata_out(pwdata_out));
	pbdw_periph_model u_model (.clk_in(core_clk_in), .psel_in(psel_out),
		.paddr_in(paddr_out), .rdata_out(periph_rdata_in));

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int reg_of(pbdw_addr_t a);
		for (int i = 0; i < NR; i++) begin
			if (a >= lo_t[i] && a <= hi_t[i]) return i;
		end
		return -1;
	endfunction

	// unequal clocks: bench ticks every third cycle, so n ticks = 3n
	function automatic int lat(pbdw_addr_t a, logic wr);
		int i, n;
		i = reg_of(a);
		if (i < 0) return 1;
		n = neq_t[i];
		if (i == 7) n = wr ? int'(PWM_WR[pwm_ratio_in]) :
			int'(PWM_RD[pwm_ratio_in]);
		if (!pbm[i] || clocks_equal_in) return n + 1;
		return 3 * ((i == 7) ? n : 2);
	endfunction

	function automatic logic [3:0] unit_of(pbdw_addr_t a);
		if (a >= PORT_BASE && a <= PORT_TOP)
			return 4'((a - PORT_BASE) >> PORT_SH);
		if (a >= PWM_BASE && a <= PWM_TOP) return 4'((a - PWM_BASE) >> PWM_SH);
		if (a >= LPT_BASE && a <= LPT_TOP) return 4'((a - LPT_BASE) >> LPT_SH);
		return 4'h0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// noisy puts junk requests on the bus while busy; they must be ignored
	task automatic access(input pbdw_addr_t a, input logic wr,
		input int cont, input logic noisy);
		int k, l, ri;
		logic [31:0] d, r;
		logic done, mapped;
		pbdw_region_t xr;
		l = lat(a, wr) + cont;
		ri = reg_of(a);
		mapped = ri >= 0;
		xr = mapped ? rg_t[ri] : RG_NONE;
		d = rnd();
		k = 0;
		done = 1'b0;
		req_in = 1'b1;
		addr_in = a;
		write_in = wr;
		wdata_in = d;
		contention_in = 1'b0;
		peripheral_clock_b_tick_in = 1'b0;
		while (!done && k < 300) begin
			@(negedge core_clk_in);
			k++;
			done = ack_out;
			if (!done && k == 1)
				chk({30'h0, wait_out, psel_out}, 32'h3);
			if (!done) begin
				r = rnd();
				req_in = noisy & r[0];
				addr_in = noisy ? r : a;
				contention_in = k <= cont;
				peripheral_clock_b_tick_in = (k % 3) == 2;
			end
		end
		chk(32'(k), 32'(l));
		chk({31'h0, err_out}, {31'h0, !mapped});
		chk({30'h0, wait_out, psel_out}, 32'h0);
		chk({28'h0, region_out}, {28'h0, xr});
		chk({28'h0, unit_out}, {28'h0, unit_of(a)});
		if (!wr) chk(rdata_out, mapped ? a ^ 32'h5A5A_0000 : 32'h0);
		if (mapped) begin
			chk(paddr_out, a);
			chk({31'h0, pwrite_out}, {31'h0, wr});
			chk(pwdata_out, d);
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end

	initial begin
		#(20 * 60000);
		err_count++;
		end_of_test();
	end

	initial begin
		logic [31:0] r;
		pbdw_addr_t a;
		int i;
		rst_n_in = 1'b0;
		req_in = 1'b0;
		addr_in = 32'h0;
		write_in = 1'b0;
		wdata_in = 32'h0;
		clocks_equal_in = 1'b1;
		pwm_ratio_in = PR_ALL_EQ;
		peripheral_clock_b_tick_in = 1'b0;
		contention_in = 1'b0;
		repeat (16) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge core_clk_in);
		for (i = 0; i < NR; i++) begin
			access(lo_t[i], i[0], 0, 0);
			access(hi_t[i] & 32'hFFFF_FFFC, !i[0], 0, 0);
		end
		access(CORE_LO - 32'h4, 1'b0, 0, 0);
		access(SYS_HI + 32'h1, 1'b0, 0, 0);
		access(FLASH_HI + 32'h1, 1'b1, 0, 0);
		clocks_equal_in = 1'b0;
		access(IO_LO, 1'b0, 0, 0);
		access(DOP_HI & 32'hFFFF_FFFC, 1'b1, 0, 0);
		access(LPT_BASE + 32'h100, 1'b0, 0, 0);
		access(FLASH_LO, 1'b0, 0, 0);
		for (i = 0; i < 6; i++) begin
			pwm_ratio_in = pbdw_ratio_t'(i);
			clocks_equal_in = i == 2 || i == 4;
			for (int c = 0; c < 6; c++)
				access(PWM_BASE + 32'(c * 256), c[0], 0, 0);
		end
		clocks_equal_in = 1'b1;
		foreach (neq_t[p]) begin
			if (p < 5 || p == 9)
				access(PORT_BASE + 32'(p * 32 + 4), 1'b1, 0, 0);
		end
		access(SYS_LO + 32'h8, 1'b0, 3, 0);
		access(IO_LO, 1'b1, 5, 0);
		repeat (150) begin
			r = rnd();
			pwm_ratio_in = pbdw_ratio_t'(r[2:0] % 3'h6);
			clocks_equal_in = pwm_ratio_in == PR_ALL_EQ ||
				pwm_ratio_in == PR_D_GT_CORE_EQ_B;
			i = int'(rnd() % NR);
			a = lo_t[i] + rnd() % (hi_t[i] - lo_t[i] + 32'h1);
			access(a & 32'hFFFF_FFFC, r[3], 0, 1);
		end
		req_in = 1'b0;
		@(negedge core_clk_in);
		req_in = 1'b1;
		addr_in = FLASH_LO;
		@(negedge core_clk_in);
		req_in = 1'b0;
		repeat (3) @(negedge core_clk_in);
		rst_n_in = 1'b0;
		@(negedge core_clk_in);
		chk({30'h0, wait_out, ack_out}, 32'h0);
		rst_n_in = 1'b1;
		repeat (4) @(negedge core_clk_in);
		access(SYS_LO, 1'b0, 0, 0);
		req_in = 1'b0;
		repeat (4) @(negedge core_clk_in);
		end_of_test();
	end
endmodule
`default_nettype wire
